// ===== uart_pkg.sv
// constants, state encodings and the state record of the serial control block
// assumes a 100 MHz bus clock and a 32-bit AXI4-Lite register port
package uart_pkg;
  localparam logic [7:0] OFS_CTRL2 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  // control two bits
  localparam int B_RXIRQ = 5;
  localparam int B_QIRQ = 4;
  localparam int B_TXON = 3;
  localparam int B_RXON = 2;
  localparam int B_STBY = 1;
  localparam int B_BRK = 0;
  // control one bits
  localparam int B_LOOP = 7;
  localparam int B_RX_SOURCE_SEL = 5;
  localparam int B_NINE = 4;
  localparam int B_WAKE = 3;
  localparam int B_DIR = 0;
  // status bits
  localparam int B_TXBUSY = 6;
  localparam int B_RXFULL = 5;
  localparam int B_IDLE = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // 100 MHz / 115200 baud, minus one
  localparam logic [15:0] BAUD_RST = 16'h0363;
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] FRAME9 = 4'hB;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_BREAK, TX_PREAMBLE}
    tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  typedef struct packed {
    logic [7:0] ctrl2;
    logic [7:0] ctrl1;
    logic [15:0] baud;
    logic [8:0] tx_buf;
    logic tx_buf_full;
    logic pend_idle;
    logic pend_brk;
    tx_state_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [15:0] tx_tick;
    rx_state_t rx_st;
    logic [9:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [15:0] rx_tick;
    logic [8:0] rx_data;
    logic rx_full;
    logic idle_flag;
    logic idle_arm;
    logic [3:0] idle_cnt;
    logic [1:0] rxd_sync;
    logic [1:0] txd_sync;
    logic rx_prev;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage : uart_pkg

// ===== uart_ctrl.sv
// serial transmit/receive control with AXI4-Lite registers
// assumes one bus clock; line pins are asynchronous and synchronised here
`timescale 1ns/1ps

module uart_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd_in,
  input wire logic txd_in,
  input wire logic gp_txd_out,
  input wire logic gp_txd_oe_n,
  output logic txd_out,
  output logic txd_oe_n,
  output logic txd_port_mode,
  output logic rxd_port_mode,
  output logic irq_rx_full,
  output logic irq_quiet_line
);
  uart_pkg::state_t s_r;
  uart_pkg::state_t s_nxt;
  logic wr_go, rd_go, loop, rx_source_sel, nine, tx_busy, owns, drive;
  logic tx_line, rx_line, tx_tick_hit, rx_bit_hit, accept, msb;
  logic [3:0] len;

  function automatic logic [3:0] frame_len(input logic nine_bit);
    frame_len = nine_bit ? uart_pkg::FRAME9 : uart_pkg::FRAME8;
  endfunction : frame_len

  function automatic logic [15:0] bump(input logic [15:0] v);
    bump = 16'(v + 16'h0001);
  endfunction : bump

  ////////////////////////////////////////////////////////////////////////////
  assign loop = s_r.ctrl1[uart_pkg::B_LOOP];
  assign rx_source_sel = s_r.ctrl1[uart_pkg::B_RX_SOURCE_SEL];
  assign nine = s_r.ctrl1[uart_pkg::B_NINE];
  assign len = frame_len(nine);
  assign tx_busy = (s_r.tx_st != uart_pkg::TX_IDLE) || s_r.tx_buf_full ||
                   s_r.pend_idle || s_r.pend_brk;
  // pin stays with the transmitter while work is queued, except in loopback with rx_source_sel clear
  assign owns = (s_r.ctrl2[uart_pkg::B_TXON] || tx_busy) &&
                !(loop && !rx_source_sel);
  assign drive = owns && (!(loop && rx_source_sel) ||
                 s_r.ctrl1[uart_pkg::B_DIR]);
  assign tx_line = (s_r.tx_st == uart_pkg::TX_IDLE) | s_r.tx_sh[0];
  // receiver input source
  assign rx_line = !loop ? s_r.rxd_sync[1] :
                   (rx_source_sel && !drive) ? s_r.txd_sync[1] : tx_line;
  assign txd_out = owns ? tx_line : gp_txd_out;
  assign txd_oe_n = owns ? !drive : gp_txd_oe_n;
  assign txd_port_mode = !owns;
  assign rxd_port_mode = !s_r.ctrl2[uart_pkg::B_RXON] || loop;
  assign irq_rx_full = s_r.rx_full &&
                       s_r.ctrl2[uart_pkg::B_RXIRQ];
  assign irq_quiet_line = s_r.idle_flag &&
                          s_r.ctrl2[uart_pkg::B_QIRQ];
  // both write channels are taken together, one write at a time
  assign wr_go = awvalid && wvalid && !s_r.bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign rd_go = arvalid && !s_r.rvalid;
  assign arready = !s_r.rvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign tx_tick_hit = s_r.tx_tick == s_r.baud;
  assign rx_bit_hit = s_r.rx_tick == s_r.baud;
  assign msb = nine ? s_r.rx_sh[8] : s_r.rx_sh[7];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    accept = 1'b0;
    s_nxt.rxd_sync = {s_r.rxd_sync[0], rxd_in};
    s_nxt.txd_sync = {s_r.txd_sync[0], txd_in};
    s_nxt.rx_prev = rx_line;
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // transmitter: idle, break, then data; each frame is len bit times
    if (s_r.tx_st == uart_pkg::TX_IDLE) begin
      s_nxt.tx_tick = 16'h0000;
      s_nxt.tx_cnt = len;
      if (s_r.pend_idle) begin
        s_nxt.pend_idle = 1'b0;
        s_nxt.tx_sh = 11'h7FF;
        s_nxt.tx_st = uart_pkg::TX_PREAMBLE;
      end else if (s_r.pend_brk) begin
        s_nxt.pend_brk = 1'b0;
        s_nxt.tx_sh = 11'h000;
        s_nxt.tx_st = uart_pkg::TX_BREAK;
      end else if (s_r.tx_buf_full) begin
        s_nxt.tx_buf_full = 1'b0;
        s_nxt.tx_sh = nine ? {1'b1, s_r.tx_buf, 1'b0} :
                             {2'h3, s_r.tx_buf[7:0], 1'b0};
        s_nxt.tx_st = uart_pkg::TX_DATA;
      end
    end else if (tx_tick_hit) begin
      s_nxt.tx_tick = 16'h0000;
      s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
      s_nxt.tx_cnt = 4'(s_r.tx_cnt - 4'h1);
      if (s_r.tx_cnt == 4'h1) begin
        s_nxt.tx_st = uart_pkg::TX_IDLE;
        // a held break bit re-queues, so a late clear may add one more
        if (s_r.tx_st == uart_pkg::TX_BREAK &&
            s_r.ctrl2[uart_pkg::B_BRK]) begin
          s_nxt.pend_brk = 1'b1;
        end
      end
    end else begin
      s_nxt.tx_tick = bump(s_r.tx_tick);
    end
    // writes after the transmitter, reads before the receiver: sets win
    if (wr_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = uart_pkg::RESP_OK;
      unique case (awaddr)
        uart_pkg::OFS_CTRL2: if (wstrb[0]) begin
          s_nxt.ctrl2 = wdata[7:0];
          if (wdata[uart_pkg::B_TXON] && !s_r.ctrl2[uart_pkg::B_TXON] &&
              tx_busy) begin
            s_nxt.pend_idle = 1'b1;
          end
          if (wdata[uart_pkg::B_BRK] && !s_r.ctrl2[uart_pkg::B_BRK]) begin
            s_nxt.pend_brk = 1'b1;
          end
        end
        uart_pkg::OFS_CTRL1: if (wstrb[0]) begin
          s_nxt.ctrl1 = wdata[7:0];
        end
        uart_pkg::OFS_BAUD: begin
          if (wstrb[0]) s_nxt.baud[7:0] = wdata[7:0];
          if (wstrb[1]) s_nxt.baud[15:8] = wdata[15:8];
        end
        uart_pkg::OFS_DATA: if (wstrb[0] && s_r.ctrl2[uart_pkg::B_TXON]) begin
          s_nxt.tx_buf = wdata[8:0];
          s_nxt.tx_buf_full = 1'b1;
        end
        uart_pkg::OFS_STAT: ;
        default: s_nxt.bresp = uart_pkg::RESP_ERR;
      endcase
    end
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = uart_pkg::RESP_OK;
      s_nxt.rdata = 32'h0000_0000;
      unique case (araddr)
        uart_pkg::OFS_CTRL2: s_nxt.rdata[7:0] = s_r.ctrl2;
        uart_pkg::OFS_CTRL1: s_nxt.rdata[7:0] = s_r.ctrl1;
        uart_pkg::OFS_BAUD: s_nxt.rdata[15:0] = s_r.baud;
        uart_pkg::OFS_STAT: begin
          s_nxt.rdata[uart_pkg::B_TXBUSY] = tx_busy;
          s_nxt.rdata[uart_pkg::B_RXFULL] = s_r.rx_full;
          s_nxt.rdata[uart_pkg::B_IDLE] = s_r.idle_flag;
        end
        uart_pkg::OFS_DATA: begin
          s_nxt.rdata[8:0] = s_r.rx_data;
          s_nxt.rx_full = 1'b0;
          s_nxt.idle_flag = 1'b0;
        end
        default: s_nxt.rresp = uart_pkg::RESP_ERR;
      endcase
    end
    // receiver
    if (!s_r.ctrl2[uart_pkg::B_RXON]) begin
      s_nxt.rx_st = uart_pkg::RX_IDLE;
      s_nxt.rx_tick = 16'h0000;
      s_nxt.idle_cnt = 4'h0;
    end else begin
      unique case (s_r.rx_st)
        uart_pkg::RX_IDLE: begin
          s_nxt.rx_tick = rx_bit_hit ? 16'h0000 : bump(s_r.rx_tick);
          if (!rx_line) s_nxt.idle_cnt = 4'h0;
          if (s_r.rx_prev && !rx_line) begin
            s_nxt.rx_st = uart_pkg::RX_START;
            s_nxt.rx_tick = 16'h0000;
          end else if (rx_bit_hit && rx_line && s_r.idle_cnt != len) begin
            s_nxt.idle_cnt = 4'(s_r.idle_cnt + 4'h1);
            if (4'(s_r.idle_cnt + 4'h1) == len) begin
              if (s_r.ctrl2[uart_pkg::B_STBY]) begin
                if (!s_r.ctrl1[uart_pkg::B_WAKE]) begin
                  s_nxt.ctrl2[uart_pkg::B_STBY] = 1'b0;
                end
              end else if (s_r.idle_arm) begin
                s_nxt.idle_flag = 1'b1;
                s_nxt.idle_arm = 1'b0;
              end
            end
          end
        end
        uart_pkg::RX_START: begin
          s_nxt.rx_tick = bump(s_r.rx_tick);
          if (s_r.rx_tick == (s_r.baud >> 1)) begin
            s_nxt.rx_tick = 16'h0000;
            s_nxt.rx_cnt = 4'h0;
            s_nxt.rx_st = rx_line ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
          end
        end
        uart_pkg::RX_BITS: begin
          s_nxt.rx_tick = bump(s_r.rx_tick);
          if (rx_bit_hit) begin
            s_nxt.rx_tick = 16'h0000;
            s_nxt.rx_sh[s_r.rx_cnt] = rx_line;
            s_nxt.rx_cnt = 4'(s_r.rx_cnt + 4'h1);
            if (s_r.rx_cnt == 4'(len - 4'h2)) begin
              s_nxt.rx_st = uart_pkg::RX_IDLE;
              s_nxt.idle_cnt = 4'h0;
              accept = !s_r.ctrl2[uart_pkg::B_STBY];
              if (s_r.ctrl2[uart_pkg::B_STBY] &&
                  s_r.ctrl1[uart_pkg::B_WAKE] &&
                  msb) begin
                s_nxt.ctrl2[uart_pkg::B_STBY] = 1'b0;
                accept = 1'b1;
              end
            end
          end
        end
        default: s_nxt.rx_st = uart_pkg::RX_IDLE;
      endcase
    end
    if (accept) begin
      s_nxt.rx_data = nine ? s_nxt.rx_sh[8:0] : {1'b0, s_nxt.rx_sh[7:0]};
      s_nxt.rx_full = 1'b1;
      s_nxt.idle_arm = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.baud <= uart_pkg::BAUD_RST;
      s_r.ctrl1 <= uart_pkg::CTRL_RST;
      s_r.ctrl2 <= uart_pkg::CTRL_RST;
      s_r.tx_st <= uart_pkg::TX_IDLE;
      s_r.rx_st <= uart_pkg::RX_IDLE;
      s_r.rxd_sync <= 2'h3;
      s_r.txd_sync <= 2'h3;
      s_r.rx_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_brk_begin;
    s_r.tx_st == uart_pkg::TX_IDLE ##1 s_r.tx_st == uart_pkg::TX_BREAK;
  endsequence
  sequence s_tx_drop;
    s_r.ctrl2[uart_pkg::B_TXON] && tx_busy && !loop
    ##1 !s_r.ctrl2[uart_pkg::B_TXON] && !loop && tx_busy;
  endsequence

  property p_rx_irq;
    $rose(s_r.rx_full) && s_r.ctrl2[uart_pkg::B_RXIRQ] |-> irq_rx_full;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
  property p_quiet_irq;
    !s_r.ctrl2[uart_pkg::B_QIRQ] |-> !irq_quiet_line;
  endproperty
  a_quiet_irq: assert property (p_quiet_irq)
    else $error("quiet irq while masked");
  property p_tx_drive;
    s_r.ctrl2[uart_pkg::B_TXON] && !loop |-> !txd_oe_n && !txd_port_mode;
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("tx pin not driven");
  property p_loop_port;
    loop && !rx_source_sel |-> txd_port_mode && txd_oe_n == gp_txd_oe_n;
  endproperty
  a_loop_port: assert property (p_loop_port)
    else $error("tx pin kept in loopback");
  property p_one_wire;
    loop && rx_source_sel && !s_r.ctrl1[uart_pkg::B_DIR] |-> txd_oe_n || !owns;
  endproperty
  a_one_wire: assert property (p_one_wire)
    else $error("single wire drives while receiving");
  property p_idle_queue;
    wr_go && awaddr == uart_pkg::OFS_CTRL2 && wstrb[0] && tx_busy &&
    wdata[uart_pkg::B_TXON] && !s_r.ctrl2[uart_pkg::B_TXON]
    |=> s_r.pend_idle || s_r.tx_st == uart_pkg::TX_PREAMBLE;
  endproperty
  a_idle_queue: assert property (p_idle_queue)
    else $error("idle not queued");
  property p_keep_pin;
    s_tx_drop |-> !txd_port_mode;
  endproperty
  a_keep_pin: assert property (p_keep_pin)
    else $error("pin released early");
  property p_rx_off;
    !s_r.ctrl2[uart_pkg::B_RXON] |-> rxd_port_mode ##1
                                     s_r.rx_st == uart_pkg::RX_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receiver active while off");
  property p_break_low;
    s_brk_begin |-> !tx_line [*8];
  endproperty
  a_break_low: assert property (p_break_low)
    else $error("break not low");
endmodule : uart_ctrl

// ===== uart_remote.sv
// remote serial device: drives the receive line, decodes the tx pin
// assumes one caller at a time and BT bus clocks per bit
`timescale 1ns/1ps
module uart_remote #(
  parameter int BT = 4
) (
  input wire logic aclk,
  input wire logic pin,
  output logic line
);
  initial line = 1'b1;
  // start, data lsb first, optional ninth bit, stop; idles at mark
  task automatic send(input logic [8:0] d, input logic nine);
    int last;
    last = nine ? 9 : 8;
    for (int i = -1; i <= last; i++) begin
      @(posedge aclk);
      if (i < 0) line <= 1'b0;
      else if (i == last) line <= 1'b1;
      else line <= d[i];
      repeat (BT - 1) @(posedge aclk);
    end
  endtask : send
  // samples mid-bit; returns inside the stop bit
  task automatic recv(output logic [8:0] d, input logic nine);
    d = '0;
    @(negedge pin);
    repeat (BT / 2) @(posedge aclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BT) @(posedge aclk);
      d[i] = pin;
    end
    repeat (BT) @(posedge aclk);
  endtask : recv
endmodule : uart_remote

// ===== uart_ctrl_tb_top.sv
// self-checking bench of the serial control block and a remote device
// assumes a bit time of BT clocks, set through the baud register
`timescale 1ns/1ps
module uart_ctrl_tb_top;
  localparam int BT = 4;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
  } row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, rxd_in, txd_out;
  logic txd_oe_n, txd_port_mode, rxd_port_mode;
  logic irq_rx_full, irq_quiet_line;
  logic [8:0] v;
  int failures, n_tests, cyc, lowcnt, lc0, n;
  row_t rows[7];
  // pulled up whenever nobody drives it
  wire pin = txd_oe_n ? 1'b1 : txd_out;
  uart_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxd_in,
    .txd_in(pin), .gp_txd_out(1'b0), .gp_txd_oe_n(1'b1), .txd_out,
    .txd_oe_n, .txd_port_mode, .rxd_port_mode, .irq_rx_full,
    .irq_quiet_line);
  uart_remote #(.BT(BT)) rem (.aclk, .pin, .line(rxd_in));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // watchdog well above the fewer than two thousand cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pin === 1'b0) lowcnt <= lowcnt + 1;
    if (cyc == 30000) begin
      failures = failures + 1;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic chk1(input string w, input logic e, input logic g);
    chk(w, 32'(e), 32'(g));
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = uart_pkg::RESP_OK);
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // ready is looked at where it has settled, before the taking edge
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(r));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = uart_pkg::RESP_OK);
    logic [31:0] g;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (!rvalid);
    g = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    chk($sformatf("reg %h", a), e, g);
    chk("rresp", 32'(er), 32'(r));
  endtask : rd
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    rows = '{
      '{uart_pkg::OFS_CTRL1, 32'h19, 32'h19, uart_pkg::RESP_OK},
      '{uart_pkg::OFS_CTRL1, 32'h00, 32'h00, uart_pkg::RESP_OK},
      '{uart_pkg::OFS_CTRL2, 32'hFFFFFF30, 32'h30, uart_pkg::RESP_OK},
      '{uart_pkg::OFS_CTRL2, 32'h00, 32'h00, uart_pkg::RESP_OK},
      '{uart_pkg::OFS_BAUD, 32'h03, 32'h03, uart_pkg::RESP_OK},
      '{uart_pkg::OFS_STAT, 32'hFF, 32'h00, uart_pkg::RESP_OK},
      '{8'h14, 32'hFF, 32'h00, uart_pkg::RESP_ERR}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].r);
      rd(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("register table done");
    wr(uart_pkg::OFS_CTRL2, 32'h08);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk1("txd_port_mode", 1'b1, txd_port_mode);
    chk1("rxd_port_mode", 1'b1, rxd_port_mode);
    rd(uart_pkg::OFS_CTRL2, 32'h00);
    rd(uart_pkg::OFS_BAUD, 32'(uart_pkg::BAUD_RST));
    wr(uart_pkg::OFS_BAUD, 32'h03);
    $display("reset done");
    for (int m = 0; m < 2; m++) begin
      wr(uart_pkg::OFS_CTRL1, 32'(m) << 4);
      wr(uart_pkg::OFS_CTRL2, 32'h08);
      chk1("txd_oe_n", 1'b0, txd_oe_n);
      chk1("txd_port_mode", 1'b0, txd_port_mode);
      wr(uart_pkg::OFS_DATA, 32'h1A5);
      rem.recv(v, m[0]);
      chk("frame", m ? 32'h1A5 : 32'hA5, 32'(v));
      lc0 = lowcnt;
      wr(uart_pkg::OFS_CTRL2, 32'h09);
      wr(uart_pkg::OFS_CTRL2, 32'h08);
      repeat (14 * BT) @(posedge aclk);
      chk("break", (10 + m) * BT, lowcnt - lc0);
    end
    lc0 = lowcnt;
    wr(uart_pkg::OFS_CTRL2, 32'h09);
    repeat (25 * BT) @(posedge aclk);
    wr(uart_pkg::OFS_CTRL2, 32'h08);
    repeat (30 * BT) @(posedge aclk);
    chk("breaks", 1, 32'(lowcnt - lc0 >= 20 * BT));
    $display("transmit and break done");
    wr(uart_pkg::OFS_CTRL1, 32'h00);
    fork
      rem.recv(v, 1'b0);
      begin
        wr(uart_pkg::OFS_DATA, 32'h0F);
        wr(uart_pkg::OFS_CTRL2, 32'h00);
        chk1("txd_oe_n", 1'b0, txd_oe_n);
        wr(uart_pkg::OFS_CTRL2, 32'h08);
        wr(uart_pkg::OFS_DATA, 32'h33);
      end
    join
    chk("frame", 32'h0F, 32'(v));
    n = 0;
    while (pin !== 1'b0) begin
      @(posedge aclk);
      n++;
    end
    chk("gap", 1, 32'(n >= 10 * BT));
    repeat (11 * BT) @(posedge aclk);
    wr(uart_pkg::OFS_DATA, 32'h00);
    wr(uart_pkg::OFS_CTRL2, 32'h00);
    repeat (4 * BT) @(posedge aclk);
    chk1("txd_oe_n", 1'b0, txd_oe_n);
    repeat (8 * BT) @(posedge aclk);
    chk1("txd_port_mode", 1'b1, txd_port_mode);
    $display("queued idle and release done");
    wr(uart_pkg::OFS_CTRL2, 32'h0C);
    wr(uart_pkg::OFS_CTRL1, 32'h80);
    chk1("txd_port_mode", 1'b1, txd_port_mode);
    chk1("txd_oe_n", 1'b1, txd_oe_n);
    chk1("txd_out", 1'b0, txd_out);
    chk1("rxd_port_mode", 1'b1, rxd_port_mode);
    fork
      rem.send(9'h000, 1'b0);
      wr(uart_pkg::OFS_DATA, 32'h3C);
    join
    repeat (12 * BT) @(posedge aclk);
    chk1("irq_rx_full", 1'b0, irq_rx_full);
    wr(uart_pkg::OFS_CTRL2, 32'h2C);
    chk1("irq_rx_full", 1'b1, irq_rx_full);
    rd(uart_pkg::OFS_DATA, 32'h3C);
    chk1("irq_rx_full", 1'b0, irq_rx_full);
    wr(uart_pkg::OFS_CTRL1, 32'hA1);
    chk1("txd_oe_n", 1'b0, txd_oe_n);
    wr(uart_pkg::OFS_CTRL1, 32'hA0);
    chk1("txd_oe_n", 1'b1, txd_oe_n);
    repeat (12 * BT) @(posedge aclk);
    rd(uart_pkg::OFS_DATA, 32'h3C);
    $display("loop modes done");
    wr(uart_pkg::OFS_CTRL1, 32'h00);
    wr(uart_pkg::OFS_CTRL2, 32'h1C);
    chk1("rxd_port_mode", 1'b0, rxd_port_mode);
    rem.send(9'h0A5, 1'b0);
    repeat (2 * BT) @(posedge aclk);
    chk1("irq_quiet_line", 1'b0, irq_quiet_line);
    repeat (12 * BT) @(posedge aclk);
    chk1("irq_quiet_line", 1'b1, irq_quiet_line);
    rd(uart_pkg::OFS_DATA, 32'hA5);
    wr(uart_pkg::OFS_CTRL2, 32'h08);
    chk1("rxd_port_mode", 1'b1, rxd_port_mode);
    rem.send(9'h011, 1'b0);
    repeat (14 * BT) @(posedge aclk);
    rd(uart_pkg::OFS_STAT, 32'h00);
    $display("receive done");
    wr(uart_pkg::OFS_CTRL1, 32'h08);
    wr(uart_pkg::OFS_CTRL2, 32'h0E);
    rem.send(9'h012, 1'b0);
    repeat (2 * BT) @(posedge aclk);
    rd(uart_pkg::OFS_STAT, 32'h00);
    rd(uart_pkg::OFS_CTRL2, 32'h0E);
    rem.send(9'h085, 1'b0);
    repeat (2 * BT) @(posedge aclk);
    rd(uart_pkg::OFS_CTRL2, 32'h0C);
    rd(uart_pkg::OFS_DATA, 32'h85);
    wr(uart_pkg::OFS_CTRL1, 32'h00);
    wr(uart_pkg::OFS_CTRL2, 32'h0E);
    repeat (24 * BT) @(posedge aclk);
    rd(uart_pkg::OFS_CTRL2, 32'h0C);
    $display("standby done");
    test_done();
  end
endmodule : uart_ctrl_tb_top
